// ===== urb_frame_src.sv
// Purpose: Remote transmitter model seen through the bit front end
// Assumes: Bits come as one-cycle strobes, LSB first
// Notes:   Data line never holds a stale bit between strobes

`timescale 1ns/1ps

module urb_frame_src (
    // Clock
    input  wire logic clk,
    // Front end pulses
    output logic      start_det,
    output logic      bit_strobe,
    output logic      bit_val
);
    // Quiet line at time zero
    initial begin
        start_det  = 1'b0;
        bit_strobe = 1'b0;
        bit_val    = 1'b0;
    end

    // One voted bit; line flips after so a stale value never matches
    task automatic put(input logic b, input int gap);
        @(posedge clk);
        bit_strobe <= 1'b1;
        bit_val    <= b;
        @(posedge clk);
        bit_strobe <= 1'b0;
        bit_val    <= ~b;
        repeat (gap) @(posedge clk);
    endtask : put

    // Start, data LSB first, parity if par >= 0, one stop bit
    task automatic send(input logic [8:0] d, input int n, input int par,
                        input logic stp, input int gap);
        @(posedge clk);
        start_det <= 1'b1;
        @(posedge clk);
        start_det <= 1'b0;
        for (int i = 0; i < n; i++) put(d[i], gap);
        if (par >= 0) put(par[0], gap);
        put(stp, gap);
    endtask : send
endmodule : urb_frame_src

// ===== urb_pkg.sv
// Purpose: Shared constants for the serial receive buffer and status block
// Assumes: Byte-wide register port, registers at word indices 0..3
// Notes:   Bit positions and reset values are named here once

package urb_pkg;

    // Register port geometry
    localparam int          URB_ADDR_W       = 2;
    localparam int          URB_DATA_W       = 8;

    // Register indices
    localparam logic [1:0]  URB_OFS_STATUS_A = 2'h0;
    localparam logic [1:0]  URB_OFS_CTRL_B   = 2'h1;
    localparam logic [1:0]  URB_OFS_CTRL_C   = 2'h2;
    localparam logic [1:0]  URB_OFS_DATA     = 2'h3;

    // Status A field positions
    localparam int          URB_A_RXC        = 7;
    localparam int          URB_A_FE         = 4;
    localparam int          URB_A_DOR        = 3;
    localparam int          URB_A_PE         = 2;

    // Control B field positions
    localparam int          URB_B_RXCIE      = 7;
    localparam int          URB_B_RXEN       = 4;
    localparam int          URB_B_SIZE2      = 2;
    localparam int          URB_B_RX9        = 1;
    localparam int          URB_B_TX9        = 0;

    // Control C field positions
    localparam int          URB_C_PAR_EN     = 5;
    localparam int          URB_C_PAR_ODD    = 4;
    localparam int          URB_C_STOP2      = 3;
    localparam int          URB_C_SIZE_HI    = 2;
    localparam int          URB_C_SIZE_LO    = 1;

    // Reset values of the writable registers
    localparam logic [7:0]  URB_RST_CTRL_B   = 8'h00;
    localparam logic [7:0]  URB_RST_CTRL_C   = 8'h06;

    // Character size code for nine-bit frames
    localparam logic [2:0]  URB_SIZE_9BIT    = 3'h7;

    // Receive frame states
    typedef enum logic [1:0] {
        URB_ST_IDLE = 2'b00,
        URB_ST_DATA = 2'b01,
        URB_ST_PAR  = 2'b10,
        URB_ST_STOP = 2'b11
    } urb_state_t;

endpackage : urb_pkg

// ===== urb_rx_buffer.sv
// Purpose: Receive shift logic, two-entry receive FIFO, status and flags
// Assumes: Front end delivers start and voted bits on the system clock
// Notes:   Baud timing and majority voting live outside this block

`timescale 1ns/1ps

module urb_rx_buffer
    import urb_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Register port
    input  wire logic [URB_ADDR_W-1:0] reg_addr,
    input  wire logic [URB_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [URB_DATA_W-1:0] reg_rdata,
    // Bit front end
    input  wire logic                  start_det,
    input  wire logic                  bit_strobe,
    input  wire logic                  bit_val,
    // System side
    output logic                       rx_irq,
    output logic                       rx_pin_override
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int ENT_W = 12;

    // Data bits for a size code
    function automatic logic [3:0] size_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h8;
        case (code)
            3'h0:    n = 4'h5;
            3'h1:    n = 4'h6;
            3'h2:    n = 4'h7;
            3'h7:    n = 4'h9;
            default: n = 4'h8;
        endcase
        return n;
    endfunction : size_bits

    // Pointer advance with wrap
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction : ptr_inc

    // Control registers
    logic [URB_DATA_W-1:0] ctrl_b_ff;        // Enables and size bit
    logic [URB_DATA_W-1:0] ctrl_c_ff;        // Parity, stop, size
    logic [URB_DATA_W-1:0] rdata_ff;         // Read data register

    // Receive engine
    urb_state_t            state_ff;         // Frame position
    urb_state_t            nxt_state;
    logic [8:0]            shreg_ff;         // Serial shift register
    logic [3:0]            bitcnt_ff;        // Data bits taken
    logic                  pbit_ff;          // Received parity bit
    logic [8:0]            hold_data_ff;     // Completed frame waiting
    logic                  hold_fe_ff;       // Stop bit was low
    logic                  hold_pe_ff;       // Parity mismatch seen
    logic                  hold_vld_ff;      // Slot holds a frame
    logic                  dor_pend_ff;      // Lost frame not yet reported

    // FIFO storage: {dor, pe, fe, data[8:0]}
    logic [ENT_W-1:0]      mem_ff [DEPTH];
    logic [PTR_W-1:0]      wptr_ff;
    logic [PTR_W-1:0]      rptr_ff;
    logic [CNT_W-1:0]      count_ff;

    // Field decode
    wire        rx_en      = ctrl_b_ff[URB_B_RXEN];
    wire        rxcie      = ctrl_b_ff[URB_B_RXCIE];
    wire        par_en     = ctrl_c_ff[URB_C_PAR_EN];
    wire        par_odd    = ctrl_c_ff[URB_C_PAR_ODD];
    wire [2:0]  size_code  = {ctrl_b_ff[URB_B_SIZE2],
                              ctrl_c_ff[URB_C_SIZE_HI:URB_C_SIZE_LO]};
    wire [3:0]  nbits      = size_bits(size_code);
    wire [8:0]  data_mask  = 9'h1FF >> (4'h9 - nbits);

    // Bus decode
    wire        wr_b       = reg_wr && (reg_addr == URB_OFS_CTRL_B);
    wire        wr_c       = reg_wr && (reg_addr == URB_OFS_CTRL_C);
    wire        rd_data    = reg_rd && (reg_addr == URB_OFS_DATA);

    // FIFO conditions
    wire        fifo_empty = (count_ff == '0);
    wire        fifo_full  = (count_ff == CNT_W'(DEPTH));
    wire        rx_cmpl    = !fifo_empty;
    wire        pop        = rd_data && !fifo_empty;
    wire        push       = hold_vld_ff && !fifo_full && rx_en;
    wire        overrun    = start_det && hold_vld_ff && fifo_full
                             && rx_en;

    // Head entry fields, zero when empty
    wire [ENT_W-1:0] head    = fifo_empty ? '0 : mem_ff[rptr_ff];
    wire [8:0]       head_d  = head[8:0];
    wire             head_fe = head[9];
    wire             head_pe = head[10];
    wire             head_dr = head[11];

    // Stop-bit frame assembly
    wire        frame_end  = (state_ff == URB_ST_STOP) && bit_strobe;
    wire [8:0]  frame_d    = (shreg_ff >> (4'h9 - nbits)) & data_mask;
    wire        par_calc   = ^frame_d ^ pbit_ff ^ par_odd;
    wire        frame_pe   = par_en && par_calc;
    wire        frame_fe   = !bit_val;
    wire        last_bit   = (bitcnt_ff == nbits - 4'h1);

    // Read mux; status writes are not stored
    wire [URB_DATA_W-1:0] stat_a = (URB_DATA_W'(rx_cmpl) << URB_A_RXC)
                                 | (URB_DATA_W'(head_fe) << URB_A_FE)
                                 | (URB_DATA_W'(head_dr) << URB_A_DOR)
                                 | (URB_DATA_W'(head_pe) << URB_A_PE);
    wire [URB_DATA_W-1:0] ctrl_b_rd = (ctrl_b_ff & ~(8'h01 << URB_B_RX9))
                                    | (URB_DATA_W'(head_d[8]) << URB_B_RX9);
    wire [URB_DATA_W-1:0] rd_mux =
        (reg_addr == URB_OFS_STATUS_A) ? stat_a    :
        (reg_addr == URB_OFS_CTRL_B)   ? ctrl_b_rd :
        (reg_addr == URB_OFS_CTRL_C)   ? ctrl_c_ff : head_d[7:0];

    // Outputs
    assign reg_rdata       = rdata_ff;
    assign rx_irq          = rxcie && rx_cmpl;
    assign rx_pin_override = rx_en;

    // Control register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_b_ff <= URB_RST_CTRL_B;
            ctrl_c_ff <= URB_RST_CTRL_C;
        end else begin
            if (wr_b) begin
                ctrl_b_ff <= reg_wdata;
            end
            if (wr_c) begin
                ctrl_c_ff <= reg_wdata;
            end
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end
    end

    // Frame state transitions
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            URB_ST_IDLE: begin
                if (start_det) begin
                    nxt_state = URB_ST_DATA;
                end
            end
            URB_ST_DATA: begin
                // Parity slot only when checking is on
                if (bit_strobe && last_bit) begin
                    nxt_state = par_en ? URB_ST_PAR : URB_ST_STOP;
                end
            end
            URB_ST_PAR: begin
                if (bit_strobe) begin
                    nxt_state = URB_ST_STOP;
                end
            end
            URB_ST_STOP: begin
                // Further stop bits are left to the idle line
                if (bit_strobe) begin
                    nxt_state = URB_ST_IDLE;
                end
            end
            default: nxt_state = URB_ST_IDLE;
        endcase
    end

    // Shift engine; disable drops it at once
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_en) begin
            state_ff  <= URB_ST_IDLE;
            shreg_ff  <= '0;
            bitcnt_ff <= '0;
            pbit_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == URB_ST_IDLE) begin
                bitcnt_ff <= '0;
            end
            if (bit_strobe && state_ff == URB_ST_DATA) begin
                shreg_ff  <= {bit_val, shreg_ff[8:1]};
                bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (bit_strobe && state_ff == URB_ST_PAR) begin
                pbit_ff <= bit_val;
            end
        end
    end

    // Holding slot between shift register and FIFO
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_en) begin
            hold_vld_ff  <= 1'b0;
            hold_data_ff <= '0;
            hold_fe_ff   <= 1'b0;
            hold_pe_ff   <= 1'b0;
        end else if (frame_end) begin
            hold_vld_ff  <= 1'b1;
            hold_data_ff <= frame_d;
            hold_fe_ff   <= frame_fe;
            hold_pe_ff   <= frame_pe;
        end else if (push || overrun) begin
            // Overrun discards the waiting character
            hold_vld_ff  <= 1'b0;
        end
    end

    // Overrun pending until a frame reaches the FIFO
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_en) begin
            dor_pend_ff <= 1'b0;
        end else if (overrun) begin
            dor_pend_ff <= 1'b1;
        end else if (push) begin
            dor_pend_ff <= 1'b0;
        end
    end

    // FIFO pointers and fill count
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_en) begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= ptr_inc(wptr_ff);
            end
            if (pop) begin
                rptr_ff <= ptr_inc(rptr_ff);
            end
            if (push && !pop) begin
                count_ff <= count_ff + CNT_W'(1);
            end else if (pop && !push) begin
                count_ff <= count_ff - CNT_W'(1);
            end
        end
    end

    // FIFO storage; flags travel with their frame
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= {dor_pend_ff, hold_pe_ff,
                                hold_fe_ff, hold_data_ff};
        end
    end

    // Checks on the receive path
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_FLUSH_ON_DISABLE:
        assert property (!rx_en |=> fifo_empty && !hold_vld_ff)
        else $error("FIFO not flushed after receiver disable");

    AST_IRQ_FOLLOWS_FLAG:
        assert property (rx_irq == (rxcie && count_ff != '0))
        else $error("Interrupt request disagrees with complete flag");

    AST_NO_ERROR_IRQ:
        assert property (fifo_empty |-> !rx_irq)
        else $error("Interrupt raised with empty FIFO");

    AST_STATUS_RXC_READ:
        assert property (reg_rd && reg_addr == URB_OFS_STATUS_A
                         |=> reg_rdata[URB_A_RXC] == $past(count_ff != '0))
        else $error("Complete flag read wrong");

    AST_POP_ADVANCES:
        // A disable in the same cycle flushes instead of popping
        assert property (pop && !push && rx_en |=> count_ff == $past(count_ff) - CNT_W'(1)
                         && rptr_ff == ptr_inc($past(rptr_ff)))
        else $error("Data read did not advance FIFO");

    AST_STATUS_WRITE_INERT:
        assert property (reg_wr && reg_addr == URB_OFS_STATUS_A && !push && !pop
                         && rx_en |=> $stable(head))
        else $error("Status write altered head entry");

    AST_PARITY_OFF_ZERO:
        assert property (frame_end && !par_en |=> !hold_pe_ff)
        else $error("Parity error stored with checking off");

    AST_FRAME_ERROR:
        assert property (frame_end && rx_en |=> hold_fe_ff == !$past(bit_val))
        else $error("Frame error does not follow stop bit");

    AST_OVERRUN_SET:
        assert property (overrun |=> dor_pend_ff && !hold_vld_ff)
        else $error("Overrun not recorded or held frame kept");

    AST_OVERRUN_CLEAR:
        assert property (push && !overrun |=> !dor_pend_ff ##0 count_ff != '0)
        else $error("Overrun pending not cleared on transfer");

    AST_UPPER_ZERO:
        // Judged at capture; a later size change must not matter
        assert property (frame_end && rx_en |=> (hold_data_ff & ~$past(data_mask)) == '0)
        else $error("Unused upper data bits not zero");

    AST_PIN_OWNER:
        assert property (rx_pin_override == ctrl_b_ff[URB_B_RXEN])
        else $error("Pin ownership disagrees with enable");

    // Reads of status, control B and data show the head entry
    AST_STATUS_FLAGS_HEAD:
        assert property (reg_rd && reg_addr == URB_OFS_STATUS_A
                         |=> reg_rdata[URB_A_FE] == $past(head_fe) && reg_rdata[URB_A_PE] == $past(head_pe))
        else $error("Status error flags do not match head entry");

    AST_NINTH_READ:
        assert property (reg_rd && reg_addr == URB_OFS_CTRL_B
                         |=> reg_rdata[URB_B_RX9] == $past(head_d[8]))
        else $error("Ninth bit read does not match head entry");

    AST_EMPTY_READ_ZERO:
        assert property (reg_rd && reg_addr == URB_OFS_DATA && fifo_empty |=> reg_rdata == '0)
        else $error("Data read from empty FIFO not zero");

    // Storage side of the receive path; shift engine idle after disable
    AST_PARITY_KEPT:
        assert property (push |=> mem_ff[$past(wptr_ff)][10] == $past(hold_pe_ff))
        else $error("Parity outcome not stored with its frame");

    AST_NO_PUSH_WHEN_FULL:
        assert property (fifo_full && !pop && rx_en |=> count_ff == CNT_W'(DEPTH))
        else $error("FIFO fill changed while full without a read");

    AST_COUNT_BOUND:
        assert property (count_ff <= CNT_W'(DEPTH))
        else $error("FIFO fill beyond its depth");

    AST_DISABLE_IDLE:
        assert property (!rx_en |=> state_ff == URB_ST_IDLE && bitcnt_ff == '0)
        else $error("Reception continued while receiver disabled");

endmodule : urb_rx_buffer

// ===== urb_rx_buffer_tb_top.sv
// Purpose: Self-checking bench for the receive buffer and status
// Assumes: Frame source model drives the bit front end
// Notes:   Expectations built from package field positions

`timescale 1ns/1ps

module urb_rx_buffer_tb_top
    import urb_pkg::*;
();
    // Design port signals
    logic       clk;
    logic       sys_rst;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       start_det;
    logic       bit_strobe;
    logic       bit_val;
    logic       rx_irq;
    logic       rx_pin_override;
    // Bench state
    int         fail_count = 0;
    int         cmp_count  = 0;
    int         gap        = 1;
    // Receiver on with completion request enabled
    localparam logic [7:0] B_ON = 8'((1 << URB_B_RXCIE) | (1 << URB_B_RXEN));

    urb_rx_buffer i_urb_rx_buffer (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start_det(start_det), .bit_strobe(bit_strobe), .bit_val(bit_val),
        .rx_irq(rx_irq), .rx_pin_override(rx_pin_override));
    urb_frame_src i_urb_frame_src (.clk(clk), .start_det(start_det),
        .bit_strobe(bit_strobe), .bit_val(bit_val));

    // 25 MHz clock
    always #20 clk = ~clk;

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Expected status A byte
    function automatic logic [7:0] sa(input logic c, input logic f, input logic o, input logic p);
        sa = 8'h00;
        sa[URB_A_RXC] = c;
        sa[URB_A_FE]  = f;
        sa[URB_A_DOR] = o;
        sa[URB_A_PE]  = p;
    endfunction : sa

    // One-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data stand only in the next cycle
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Frame then settle time for the FIFO push
    task automatic rx(input logic [8:0] d, input int n, input int par, input logic stp);
        i_urb_frame_src.send(d, n, par, stp, gap);
        repeat (3) @(posedge clk);
    endtask : rx

    // Check status, then data; reading data pops the entry
    task automatic pop(input logic [7:0] s, input logic [7:0] v);
        logic [7:0] d;
        rd(URB_OFS_STATUS_A, d);
        chk(d, s);
        rd(URB_OFS_DATA, d);
        chk(d, v);
    endtask : pop

    task automatic t_reset;
        logic [7:0] d;
        rd(URB_OFS_CTRL_B, d);
        chk(d, URB_RST_CTRL_B);
        rd(URB_OFS_CTRL_C, d);
        chk(d, URB_RST_CTRL_C);
        pop(8'h00, 8'h00);
        chk({7'h0, rx_pin_override}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_order;
        logic [7:0] d;
        wr(URB_OFS_CTRL_B, B_ON);
        #1;
        chk({7'h0, rx_pin_override}, 8'h01);
        rx(9'h03C, 8, -1, 1'b0);
        rx(9'h0C3, 8, -1, 1'b1);
        chk({7'h0, rx_irq}, 8'h01);
        wr(URB_OFS_STATUS_A, 8'h00); // Error bits written as zero
        pop(sa(1, 1, 0, 0), 8'h3C);
        chk({7'h0, rx_irq}, 8'h01);
        pop(sa(1, 0, 0, 0), 8'hC3);
        chk({7'h0, rx_irq}, 8'h00);
        pop(8'h00, 8'h00);
        // Completion request enable off: a received frame raises no request
        wr(URB_OFS_CTRL_B, 8'(1 << URB_B_RXEN));
        rx(9'h001, 8, -1, 1'b0);
        chk({7'h0, rx_irq}, 8'h00);
        // Flush by reading data until complete clears
        for (int i = 0; i < 3; i++) begin
            rd(URB_OFS_STATUS_A, d);
            if (d[URB_A_RXC] === 1'b1) rd(URB_OFS_DATA, d);
        end
        chk(d, 8'h00);
        $display("test order done");
    endtask : t_order

    task automatic t_parity;
        wr(URB_OFS_CTRL_B, B_ON);
        gap = 3;
        for (int odd = 0; odd < 2; odd++) begin
            for (int err = 0; err < 2; err++) begin
                wr(URB_OFS_CTRL_C, URB_RST_CTRL_C | 8'((1 << URB_C_PAR_EN) | (odd << URB_C_PAR_ODD)));
                rx(9'h0B5, 8, (^8'hB5) ^ odd ^ err, 1'b1);
                pop(sa(1, 0, 0, err[0]), 8'hB5);
            end
        end
        gap = 1;
        wr(URB_OFS_CTRL_C, URB_RST_CTRL_C | 8'(1 << URB_C_STOP2));
        rx(9'h0B5, 8, -1, 1'b1);
        rx(9'h04B, 8, -1, 1'b0);
        pop(sa(1, 0, 0, 0), 8'hB5);
        pop(sa(1, 1, 0, 0), 8'h4B);
        wr(URB_OFS_CTRL_C, URB_RST_CTRL_C);
        $display("test parity done");
    endtask : t_parity

    task automatic t_overrun;
        // Third frame waits in the holding slot, fourth start loses it
        for (int i = 1; i < 5; i++) rx(9'(8'h11 * i), 8, -1, 1'b1);
        pop(sa(1, 0, 0, 0), 8'h11);
        pop(sa(1, 0, 0, 0), 8'h22);
        pop(sa(1, 0, 1, 0), 8'h44);
        rx(9'h055, 8, -1, 1'b1);
        pop(sa(1, 0, 0, 0), 8'h55);
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_nine;
        logic [7:0] d;
        wr(URB_OFS_CTRL_B, B_ON | 8'(1 << URB_B_SIZE2));
        rx(9'h1A5, 9, -1, 1'b1);
        rd(URB_OFS_STATUS_A, d);
        chk(d, sa(1, 0, 0, 0));
        rd(URB_OFS_CTRL_B, d);
        chk({7'h0, d[URB_B_RX9]}, 8'h01);
        rd(URB_OFS_DATA, d);
        chk(d, 8'hA5);
        // Five- to seven-bit characters
        wr(URB_OFS_CTRL_B, B_ON);
        for (int s = 0; s < 3; s++) begin
            wr(URB_OFS_CTRL_C, 8'(s << URB_C_SIZE_LO));
            rx(9'h1FF, 5 + s, -1, 1'b1);
            pop(sa(1, 0, 0, 0), 8'((1 << (5 + s)) - 1));
        end
        wr(URB_OFS_CTRL_C, URB_RST_CTRL_C);
        $display("test nine done");
    endtask : t_nine

    task automatic t_disable;
        rx(9'h077, 8, -1, 1'b1);
        // Drop the enable in mid-frame; the tail must be ignored
        fork
            i_urb_frame_src.send(9'h0EE, 8, -1, 1'b1, gap);
            begin
                repeat (8) @(posedge clk);
                wr(URB_OFS_CTRL_B, 8'h00);
            end
        join
        chk({6'h0, rx_pin_override, rx_irq}, 8'h00);
        pop(8'h00, 8'h00);
        wr(URB_OFS_CTRL_B, B_ON);
        rx(9'h099, 8, -1, 1'b1);
        pop(sa(1, 0, 0, 0), 8'h99);
        pop(8'h00, 8'h00);
        $display("test disable done");
    endtask : t_disable

    // Counts, verdict, end of run
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        clk       = 1'b0;
        sys_rst   = 1'b1;
        reg_addr  = 2'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_order();
        t_parity();
        t_overrun();
        t_nine();
        t_disable();
        summarize();
    end

    // Watchdog, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule : urb_rx_buffer_tb_top
